// ### tpl_pkg.sv
// Purpose: constants and carrier types for the two-channel touch-probe position latch
// Assumes: object-dictionary indices double as the register addresses of the access port
// Notes: channel 2 fields sit CH_STRIDE bits above the channel 1 fields in both words
package tpl_pkg;

  // object-dictionary indices
  localparam logic [15:0] IDX_CTRL = 16'h60b8;
  localparam logic [15:0] IDX_STATE = 16'h60b9;
  localparam logic [15:0] IDX_POS_C1_RISE = 16'h60ba;
  localparam logic [15:0] IDX_POS_C1_FALL = 16'h60bb;
  localparam logic [15:0] IDX_POS_C2_RISE = 16'h60bc;
  localparam logic [15:0] IDX_POS_C2_FALL = 16'h60bd;
  localparam logic [15:0] IDX_CNT_C1_RISE = 16'h60d5;
  localparam logic [15:0] IDX_CNT_C1_FALL = 16'h60d6;
  localparam logic [15:0] IDX_CNT_C2_RISE = 16'h60d7;
  localparam logic [15:0] IDX_CNT_C2_FALL = 16'h60d8;

  // control word field positions within one channel
  localparam int CH_STRIDE = 8;
  localparam int CTRL_EN = 0;
  localparam int CTRL_CONT = 1;
  localparam int CTRL_SRC = 2;
  localparam int CTRL_RISE = 4;
  localparam int CTRL_FALL = 5;

  // status word field positions within one channel
  localparam int STAT_EN = 0;
  localparam int STAT_RISE = 1;
  localparam int STAT_FALL = 2;

  // edge index inside the per-channel arrays
  localparam int EDGE_RISE = 0;
  localparam int EDGE_FALL = 1;

  // pin vector layout: probe 1, probe 2, encoder index
  localparam int PIN_INDEX = 2;
  localparam int NUM_PINS = 3;

  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] STATE_RESET = 16'h0000;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] index;
    logic [15:0] wdata;
  } tpl_od_req_t;

endpackage : tpl_pkg

// ### tpl_probe_latch.sv
// Purpose: two-channel touch-probe latch capturing position feedback on probe or index edges
// Assumes: pos_fb_i is produced on ref_clk_i; probe and index pins are asynchronous
// Notes: registers are reached by object-dictionary index over od_req_i
//
// Summary of operation
// - ctrl bit0 enables ch1, bit1 continuous mode
// - ctrl bit8 enables ch2, bit9 continuous mode
// - single-shot captures once, then waits re-arm
// - ctrl bit2 picks probe1 or index for ch1
// - ctrl bit10 picks probe2 or index for ch2
// - ctrl bits4,5 gate ch1 rising, falling edges
// - ctrl bits12,13 gate ch2 rising, falling edges
// - reserved ctrl bits steer nothing
// - status bit0 ch1 enabled, bit1 rise latched
// - status bit2 ch1 falling edge latched
// - status bit8 ch2 enabled, bit9 rise latched
// - status bit10 ch2 fall; other bits zero
// - each capture stores signed 32-bit position
// - 16-bit counter per channel edge counts latches
`timescale 1ns/1ps
module tpl_probe_latch #(
  parameter int POS_W = 32,
  parameter int CNT_W = 16
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire tpl_pkg::tpl_od_req_t od_req_i,
  input wire logic [1:0] probe_i,
  input wire logic index_i,
  input wire logic signed [POS_W-1:0] pos_fb_i,
  output logic [31:0] od_rdata_o,
  output logic od_rvalid_o,
  output logic od_err_o,
  output logic [15:0] probe_state_o
);
  import tpl_pkg::*;

  logic [15:0] ctrl;
  logic [NUM_PINS-1:0] sync1;
  logic [NUM_PINS-1:0] sync2;
  logic [NUM_PINS-1:0] sync3;
  logic [NUM_PINS-1:0] pin_level;
  logic [NUM_PINS-1:0] pin_level_d;
  logic [NUM_PINS-1:0] next_pin_level;
  logic [NUM_PINS-1:0] pin_rise;
  logic [NUM_PINS-1:0] pin_fall;
  logic [1:0][1:0] trig_edge;
  logic [1:0][1:0] cap_go;
  logic [1:0][1:0] latched;
  logic [1:0] ch_en;
  logic [1:0] ch_cont;
  logic [1:0] ch_src;
  logic [1:0][1:0] edge_en;
  logic signed [POS_W-1:0] cap_pos [2][2];
  logic [CNT_W-1:0] cap_cnt [2][2];
  logic [15:0] next_state;

  // picks the edge of the channel's own probe pin or of the shared index pin
  function automatic logic pick_edge(input logic [NUM_PINS-1:0] edges, input int ch,
                                     input logic use_index);
    pick_edge = use_index ? edges[PIN_INDEX] : edges[ch];
  endfunction : pick_edge

  // control word; reserved bits are stored and read back but steer nothing
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl <= CTRL_RESET;
    end else if (od_req_i.wr && od_req_i.index == IDX_CTRL) begin
      ctrl <= od_req_i.wdata;
    end
  end

  // three-stage synchroniser; sync1 feeds only sync2
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= {index_i, probe_i};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // a level change counts only once stages two and three agree
  always_comb begin
    for (int p = 0; p < NUM_PINS; p++) begin
      next_pin_level[p] = (sync2[p] == sync3[p]) ? sync3[p] : pin_level[p];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_level <= '0;
      pin_level_d <= '0;
    end else begin
      pin_level <= next_pin_level;
      pin_level_d <= pin_level;
    end
  end

  // edges taken per pin before the source mux, so switching source makes no edge
  assign pin_rise = pin_level & ~pin_level_d;
  assign pin_fall = ~pin_level & pin_level_d;

  genvar gc;
  generate
    for (gc = 0; gc < 2; gc++) begin : g_ch
      assign ch_en[gc] = ctrl[gc*CH_STRIDE + CTRL_EN];
      assign ch_cont[gc] = ctrl[gc*CH_STRIDE + CTRL_CONT];
      assign ch_src[gc] = ctrl[gc*CH_STRIDE + CTRL_SRC];
      assign edge_en[gc][EDGE_RISE] = ctrl[gc*CH_STRIDE + CTRL_RISE];
      assign edge_en[gc][EDGE_FALL] = ctrl[gc*CH_STRIDE + CTRL_FALL];
      assign trig_edge[gc][EDGE_RISE] = pick_edge(pin_rise, gc, ch_src[gc]);
      assign trig_edge[gc][EDGE_FALL] = pick_edge(pin_fall, gc, ch_src[gc]);
      for (genvar ge = 0; ge < 2; ge++) begin : g_edge
        // single-shot edge stays blocked while its latch flag is held
        assign cap_go[gc][ge] = ch_en[gc] && edge_en[gc][ge] && trig_edge[gc][ge]
                                && (ch_cont[gc] || !latched[gc][ge]);
      end
    end
  endgenerate

  // latch flags; capture needs the enable, so set and clear never meet
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latched <= '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        for (int e = 0; e < 2; e++) begin
          if (cap_go[c][e]) begin
            latched[c][e] <= 1'b1;
          end else if (!ch_en[c]) begin
            latched[c][e] <= 1'b0;
          end
        end
      end
    end
  end

  // captured positions and latch counters; counters wrap past the top
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int c = 0; c < 2; c++) begin
        for (int e = 0; e < 2; e++) begin
          cap_pos[c][e] <= '0;
          cap_cnt[c][e] <= '0;
        end
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        for (int e = 0; e < 2; e++) begin
          if (cap_go[c][e]) begin
            cap_pos[c][e] <= pos_fb_i;
            cap_cnt[c][e] <= cap_cnt[c][e] + 1'b1;
          end
        end
      end
    end
  end

  // status word built from next-cycle flags so it tracks latched without lag
  always_comb begin
    next_state = STATE_RESET;
    for (int c = 0; c < 2; c++) begin
      next_state[c*CH_STRIDE + STAT_EN] = ch_en[c];
      next_state[c*CH_STRIDE + STAT_RISE] = cap_go[c][EDGE_RISE] ||
        (latched[c][EDGE_RISE] && ch_en[c]);
      next_state[c*CH_STRIDE + STAT_FALL] = cap_go[c][EDGE_FALL] ||
        (latched[c][EDGE_FALL] && ch_en[c]);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      probe_state_o <= STATE_RESET;
    end else begin
      probe_state_o <= next_state;
    end
  end

  // read port: answer one cycle after rd, unmapped index reads zero and flags error
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      od_rdata_o <= RDATA_RESET;
      od_rvalid_o <= 1'b0;
      od_err_o <= 1'b0;
    end else begin
      od_rvalid_o <= od_req_i.rd;
      od_err_o <= 1'b0;
      od_rdata_o <= RDATA_RESET;
      if (od_req_i.rd) begin
        case (od_req_i.index)
          IDX_CTRL: od_rdata_o <= {16'h0000, ctrl};
          IDX_STATE: od_rdata_o <= {16'h0000, probe_state_o};
          IDX_POS_C1_RISE: od_rdata_o <= 32'(cap_pos[0][EDGE_RISE]);
          IDX_POS_C1_FALL: od_rdata_o <= 32'(cap_pos[0][EDGE_FALL]);
          IDX_POS_C2_RISE: od_rdata_o <= 32'(cap_pos[1][EDGE_RISE]);
          IDX_POS_C2_FALL: od_rdata_o <= 32'(cap_pos[1][EDGE_FALL]);
          IDX_CNT_C1_RISE: od_rdata_o <= 32'(cap_cnt[0][EDGE_RISE]);
          IDX_CNT_C1_FALL: od_rdata_o <= 32'(cap_cnt[0][EDGE_FALL]);
          IDX_CNT_C2_RISE: od_rdata_o <= 32'(cap_cnt[1][EDGE_RISE]);
          IDX_CNT_C2_FALL: od_rdata_o <= 32'(cap_cnt[1][EDGE_FALL]);
          default: od_err_o <= 1'b1;
        endcase
      end
    end
  end

  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_single_shot_hold: assert property (
    (latched[0][EDGE_RISE] && !ch_cont[0]) |-> !cap_go[0][EDGE_RISE])
    else $error("single-shot ch1 rise captured twice");

  a_single_shot_ch2: assert property (
    (latched[1][EDGE_FALL] && !ch_cont[1]) |-> !cap_go[1][EDGE_FALL])
    else $error("single-shot ch2 fall captured twice");

  a_enable_gate: assert property (
    !ctrl[CTRL_EN] |-> (cap_go[0] == 2'b00))
    else $error("disabled ch1 captured");

  a_ch2_enable_gate: assert property (
    !ctrl[CH_STRIDE + CTRL_EN] |-> (cap_go[1] == 2'b00))
    else $error("disabled ch2 captured");

  a_rise_gate: assert property (
    !ctrl[CTRL_RISE] |-> !cap_go[0][EDGE_RISE])
    else $error("ch1 rise captured while gated");

  a_fall_gate_ch2: assert property (
    !ctrl[CH_STRIDE + CTRL_FALL] |-> !cap_go[1][EDGE_FALL])
    else $error("ch2 fall captured while gated");

  a_src_probe: assert property (
    (cap_go[0][EDGE_RISE] && !ctrl[CTRL_SRC]) |-> pin_rise[0])
    else $error("ch1 captured without probe edge");

  a_src_index: assert property (
    (cap_go[1][EDGE_RISE] && ctrl[CH_STRIDE + CTRL_SRC]) |-> pin_rise[PIN_INDEX])
    else $error("ch2 captured without index edge");

  a_pos_capture: assert property (
    cap_go[0][EDGE_FALL] |=> cap_pos[0][EDGE_FALL] == $past(pos_fb_i))
    else $error("captured position wrong");

  a_count_step: assert property (
    cap_go[1][EDGE_RISE] |=> cap_cnt[1][EDGE_RISE] == $past(cap_cnt[1][EDGE_RISE]) + 1'b1)
    else $error("latch counter did not step");

  a_disable_clear: assert property (
    !ch_en[0] ##1 !ch_en[0] |-> probe_state_o[STAT_RISE +: 2] == 2'b00)
    else $error("latch status kept while disabled");

  a_status_zero: assert property (
    probe_state_o[7:3] == 5'h00 && probe_state_o[15:11] == 5'h00)
    else $error("reserved status bits set");

  a_status_enable: assert property (
    ##1 probe_state_o[STAT_EN] == $past(ch_en[0]) &&
    probe_state_o[CH_STRIDE + STAT_EN] == $past(ch_en[1]))
    else $error("status enable mismatch");

  // second cycle allows for a disable written right after the capture
  a_status_latch: assert property (
    cap_go[0][EDGE_FALL] |=> probe_state_o[STAT_FALL] ##1
    (probe_state_o[STAT_FALL] || !$past(ch_en[0])))
    else $error("ch1 fall status not raised");

  a_ch2_rise_status: assert property (
    cap_go[1][EDGE_RISE] |=> probe_state_o[CH_STRIDE + STAT_RISE])
    else $error("ch2 rise status not raised");

  a_sync_agree: assert property (
    (pin_level != $past(pin_level)) |-> ($past(sync2) ^ $past(sync3)) == '0 ||
    ((pin_level ^ $past(pin_level)) & ($past(sync2) ^ $past(sync3))) == '0)
    else $error("pin level moved without agreement");

  a_fall_gate: assert property (
    !ctrl[CTRL_FALL] |-> !cap_go[0][EDGE_FALL])
    else $error("ch1 fall captured while gated");

  a_rise_gate_ch2: assert property (
    !ctrl[CH_STRIDE + CTRL_RISE] |-> !cap_go[1][EDGE_RISE])
    else $error("ch2 rise captured while gated");

  a_src_index_ch1: assert property (
    (cap_go[0][EDGE_FALL] && ctrl[CTRL_SRC]) |-> pin_fall[PIN_INDEX])
    else $error("ch1 captured without index edge");

  a_src_probe_ch2: assert property (
    (cap_go[1][EDGE_FALL] && !ctrl[CH_STRIDE + CTRL_SRC]) |-> pin_fall[1])
    else $error("ch2 captured without probe edge");

  a_count_hold: assert property (
    !cap_go[0][EDGE_RISE] |=> $stable(cap_cnt[0][EDGE_RISE]))
    else $error("latch counter moved without capture");

  // judged from the visible status bit, not from the internal flag
  a_shot_status_block: assert property (
    (probe_state_o[STAT_RISE] && !ch_cont[0]) |-> !cap_go[0][EDGE_RISE])
    else $error("single-shot ch1 rise recaptured while shown latched");

  c_ch1_rise: cover property (cap_go[0][EDGE_RISE]);
  c_ch2_index_fall: cover property (cap_go[1][EDGE_FALL] && ch_src[1]);
  c_cont_repeat: cover property (cap_go[0][EDGE_RISE] && latched[0][EDGE_RISE]);
  c_rearm: cover property (latched[0][EDGE_RISE] ##1 !ch_en[0] ##[1:20] cap_go[0][EDGE_RISE]);

endmodule : tpl_probe_latch

// ### tpl_pin_model.sv
// Purpose: far-side model of probe pins and encoder for the probe latch bench
// Assumes: levels and position are commanded by the bench between edges
// Notes: pins move only after a clock edge, as a real input stage would see
`timescale 1ns/1ps
module tpl_pin_model (
  input wire logic ref_clk_i,
  input wire logic [2:0] lvl_i,
  input wire logic signed [31:0] pos_i,
  output logic [1:0] probe_o,
  output logic index_o,
  output logic signed [31:0] pos_o
);
  // position held steady around each edge so the capture cycle does not matter
  always_ff @(posedge ref_clk_i) begin
    probe_o <= lvl_i[1:0];
    index_o <= lvl_i[2];
    pos_o <= pos_i;
  end
endmodule : tpl_pin_model

// ### test_touch_probe_position_latch.sv
// Purpose: self-checking bench for the touch-probe position latch
// Assumes: pin edges settle within ten cycles of a level change
// Notes: all inputs change on the falling clock edge
`timescale 1ns/1ps
module test_touch_probe_position_latch;
  import tpl_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  tpl_od_req_t od_req = '0;
  logic [2:0] lvl = 3'h0;
  logic signed [31:0] pos = 32'sh0;
  logic [1:0] probe;
  logic index;
  logic signed [31:0] pos_fb;
  logic [31:0] od_rdata;
  logic od_rvalid;
  logic od_err;
  logic [15:0] probe_state;
  int miscompares = 0;
  int checked = 0;

  always #5 ref_clk_i = ~ref_clk_i;

  tpl_pin_model u_pins (.ref_clk_i(ref_clk_i), .lvl_i(lvl), .pos_i(pos), .probe_o(probe),
    .index_o(index), .pos_o(pos_fb));

  tpl_probe_latch u_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .od_req_i(od_req),
    .probe_i(probe), .index_i(index), .pos_fb_i(pos_fb), .od_rdata_o(od_rdata),
    .od_rvalid_o(od_rvalid), .od_err_o(od_err), .probe_state_o(probe_state));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  // one read; waits boundedly for the answer, then lets an edge pass
  task automatic rd(input logic [15:0] idx, input logic [31:0] exp, input logic exp_err);
    int n;
    od_req.rd = 1'b1;
    od_req.index = idx;
    @(negedge ref_clk_i);
    od_req.rd = 1'b0;
    n = 0;
    while (od_rvalid !== 1'b1 && n < 4) begin
      @(negedge ref_clk_i);
      n++;
    end
    check({31'h0, od_rvalid}, 32'h1);
    check(od_rdata, exp);
    check({31'h0, od_err}, {31'h0, exp_err});
    @(negedge ref_clk_i);
  endtask : rd

  task automatic wr(input logic [15:0] idx, input logic [15:0] data);
    od_req.wr = 1'b1;
    od_req.index = idx;
    od_req.wdata = data;
    @(negedge ref_clk_i);
    od_req.wr = 1'b0;
    @(negedge ref_clk_i);
  endtask : wr

  // capture lands five cycles after the pin flop; ten leaves margin
  task automatic pins(input logic [2:0] v, input logic signed [31:0] p);
    pos = p;
    lvl = v;
    repeat (10) @(negedge ref_clk_i);
  endtask : pins

  task automatic t_reset();
    check({16'h0, probe_state}, 32'h0);
    rd(IDX_CTRL, 32'h0, 1'b0);
    rd(IDX_POS_C1_RISE, 32'h0, 1'b0);
    rd(IDX_CNT_C2_FALL, 32'h0, 1'b0);
    rd(16'h60b7, 32'h0, 1'b1);
    wr(IDX_STATE, 16'hffff);
    rd(IDX_STATE, 32'h0, 1'b0);
  endtask : t_reset

  task automatic t_single();
    wr(IDX_CTRL, 16'h0031);
    rd(IDX_STATE, 32'h0001, 1'b0);
    pins(3'b001, 32'sd100);
    rd(IDX_STATE, 32'h0003, 1'b0);
    rd(IDX_POS_C1_RISE, 32'd100, 1'b0);
    pins(3'b000, -32'sd200);
    rd(IDX_STATE, 32'h0007, 1'b0);
    rd(IDX_POS_C1_FALL, 32'hffffff38, 1'b0);
    pins(3'b001, 32'sd300);
    rd(IDX_POS_C1_RISE, 32'd100, 1'b0);
    rd(IDX_CNT_C1_RISE, 32'd1, 1'b0);
    wr(IDX_CTRL, 16'h0000);
    rd(IDX_STATE, 32'h0000, 1'b0);
    wr(IDX_CTRL, 16'h0031);
    pins(3'b000, 32'sd300);
    rd(IDX_POS_C1_FALL, 32'd300, 1'b0);
    pins(3'b001, 32'sd400);
    rd(IDX_CNT_C1_RISE, 32'd2, 1'b0);
  endtask : t_single

  task automatic t_index_cont();
    wr(IDX_CTRL, 16'hffc8);
    rd(IDX_CTRL, 32'h0000ffc8, 1'b0);
    rd(IDX_STATE, 32'h0100, 1'b0);
    pins(3'b000, -32'sd5);
    pins(3'b011, -32'sd5);
    rd(IDX_CNT_C2_RISE, 32'd0, 1'b0);
    rd(IDX_CNT_C1_RISE, 32'd2, 1'b0);
    pins(3'b111, -32'sd5);
    pins(3'b011, -32'sd5);
    pins(3'b111, -32'sd5);
    rd(IDX_STATE, 32'h0700, 1'b0);
    rd(IDX_CNT_C2_RISE, 32'd2, 1'b0);
    rd(IDX_POS_C2_RISE, 32'hfffffffb, 1'b0);
    rd(IDX_CNT_C2_FALL, 32'd1, 1'b0);
  endtask : t_index_cont

  task automatic t_ch1_gates();
    wr(IDX_CTRL, 16'h0013);
    pins(3'b110, 32'sd7);
    rd(IDX_CNT_C1_FALL, 32'd2, 1'b0);
    pins(3'b111, 32'sd7);
    rd(IDX_CNT_C1_RISE, 32'd3, 1'b0);
    wr(IDX_CTRL, 16'h0017);
    pins(3'b011, 32'sd9);
    pins(3'b111, 32'sd9);
    rd(IDX_CNT_C1_RISE, 32'd4, 1'b0);
    rd(IDX_POS_C1_RISE, 32'd9, 1'b0);
  endtask : t_ch1_gates

  // ch2 single-shot on its own probe pin, both edges
  task automatic t_ch2_single();
    wr(IDX_CTRL, 16'h3100);
    pins(3'b101, 32'sd11);
    rd(IDX_POS_C2_FALL, 32'd11, 1'b0);
    pins(3'b111, 32'sd12);
    pins(3'b101, 32'sd13);
    rd(IDX_CNT_C2_FALL, 32'd2, 1'b0);
    rd(IDX_POS_C2_FALL, 32'd11, 1'b0);
    rd(IDX_CNT_C2_RISE, 32'd3, 1'b0);
    rd(IDX_POS_C2_RISE, 32'd12, 1'b0);
    rd(IDX_STATE, 32'h0700, 1'b0);
  endtask : t_ch2_single

  initial begin
    repeat (16) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    t_reset();
    t_single();
    t_index_cont();
    t_ch1_gates();
    t_ch2_single();
    report_and_stop();
  end

  // the tests need well under ten thousand cycles
  initial begin
    #200000;
    miscompares++;
    report_and_stop();
  end
endmodule : test_touch_probe_position_latch
